// [bench/ipls_checker.sv]
// Purpose: watches the link between the host end and the device end
// Assumes: one clock, synchronous active-low reset, counters reset too
// Notes:   age counters saturate; they only need to reach the wait figures
`timescale 1ns/10ps
`default_nettype none
module ipls_checker
	import ipls_pkg::*;
#(
	parameter int LED_WAIT = 50,
	parameter int PARK_LEAD = 30
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// host pins
	input wire logic power_on_init_n,
	input wire logic mirror_park_n,
	input wire logic light_source_allow,
	// device pins
	input wire logic mirror_power_on,
	input wire logic mirror_power_on_oe,
	input wire logic emitter_driver_on,
	input wire logic emitter_driver_on_oe,
	input wire logic [1:0] emitter_select,
	input wire logic flash_serial_clock,
	input wire logic flash_serial_out,
	input wire logic flash_select_n,
	input wire logic flash_select_n_oe,
	input wire logic companion_select_n,
	input wire logic init_done_irq_pin
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] allow_cnt, park_cnt, bit_cnt;
	logic sclk_q, frame_done;
	// ages of allow and park; frame_done marks a whole flash read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			allow_cnt <= 8'h00;
			park_cnt <= 8'h00;
			bit_cnt <= 8'h00;
			sclk_q <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			allow_cnt <= !light_source_allow ? 8'h00 :
				allow_cnt + {7'h00, allow_cnt != 8'hff};
			park_cnt <= mirror_park_n ? 8'h00 :
				park_cnt + {7'h00, park_cnt != 8'hff};
			bit_cnt <= flash_select_n ? 8'h00 :
				bit_cnt + {7'h00, flash_serial_clock && !sclk_q};
			sclk_q <= flash_serial_clock;
			frame_done <= power_on_init_n && (frame_done || bit_cnt == 8'h40);
		end
	end
	// a pulse is sixteen cycles high, then low
	sequence s_high8;
		init_done_irq_pin [*8];
	endsequence
	property p_float;
		!power_on_init_n [*4] |->
			!mirror_power_on_oe && !emitter_driver_on_oe && !flash_select_n_oe;
	endproperty
	a_float: assert property (p_float) else $error("outputs driven in init");
	property p_forced;
		!light_source_allow [*4] |-> !emitter_driver_on && emitter_select == 2'b00;
	endproperty
	a_forced: assert property (p_forced) else $error("emitter not forced");
	property p_wait;
		$rose(emitter_driver_on) |-> allow_cnt >= LED_WAIT;
	endproperty
	a_wait: assert property (p_wait) else $error("emitter released early");
	property p_held_off;
		mirror_power_on || emitter_driver_on |-> frame_done;
	endproperty
	a_held_off: assert property (p_held_off) else $error("power before config");
	property p_start;
		$rose(power_on_init_n) |-> ##[1:8] !flash_select_n;
	endproperty
	a_start: assert property (p_start) else $error("config did not start");
	property p_sclk_sel;
		flash_serial_clock |-> !flash_select_n || !companion_select_n;
	endproperty
	a_sclk_sel: assert property (p_sclk_sel) else $error("clock with no select");
	property p_one_sel;
		!(!flash_select_n && !companion_select_n);
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("both selects low");
	property p_cmd;
		$rose(flash_serial_clock) && !flash_select_n && bit_cnt < 8'h08 |->
			flash_serial_out == FLASH_CMD_READ[3'd7 - bit_cnt[2:0]];
	endproperty
	a_cmd: assert property (p_cmd) else $error("wrong command bit");
	property p_pulse;
		$rose(init_done_irq_pin) |-> s_high8 ##1 s_high8 ##1 !init_done_irq_pin;
	endproperty
	a_pulse: assert property (p_pulse) else $error("bad init pin pulse");
	property p_park_first;
		$rose(power_on_init_n) |-> mirror_park_n;
	endproperty
	a_park_first: assert property (p_park_first) else $error("park late");
	property p_park_lead;
		$fell(power_on_init_n) |-> !mirror_park_n && park_cnt >= PARK_LEAD;
	endproperty
	a_park_lead: assert property (p_park_lead) else $error("park lead short");
endmodule // ipls_checker
`default_nettype wire

// [bench/tb_init_park_led_sequencing.sv]
// Purpose: drives the host end over AXI4-Lite and judges the link
// Assumes: shortened waits: light 50, bus quiet 40, park lead 30 cycles
// Notes:   the bench plays the flash; inputs are sampled at falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_init_park_led_sequencing;
	import ipls_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, flash_word = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, emitter_sel_req = 2'b10;
	logic supplies_good = 1, emitter_on_req = 1, flash_in = 0;
	logic i2c_grant, power_off_ok, irq, cfg_done, cfg_error;
	logic [7:0] cfg_value;
	int cyc = 0, t0 = 0, n_rise = 0, n_mismatch = 0, total_checks = 0;
	ipls_link_if link();
	assign link.flash_serial_in = flash_in;
	ipls_device #(.LED_WAIT(50)) u_ipls_device (.aclk, .aresetn, .link(link),
		.emitter_on_req, .emitter_sel_req, .cfg_done, .cfg_error, .cfg_value);
	ipls_host #(.I2C_QUIET(40), .PARK_LEAD(30)) u_ipls_host (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .supplies_good, .i2c_grant, .power_off_ok, .irq,
		.link(link));
	ipls_checker #(.LED_WAIT(50), .PARK_LEAD(30)) u_ipls_checker (.aclk,
		.aresetn, .power_on_init_n(link.power_on_init_n),
		.mirror_park_n(link.mirror_park_n),
		.light_source_allow(link.light_source_allow),
		.mirror_power_on(link.mirror_power_on),
		.mirror_power_on_oe(link.mirror_power_on_oe),
		.emitter_driver_on(link.emitter_driver_on),
		.emitter_driver_on_oe(link.emitter_driver_on_oe),
		.emitter_select(link.emitter_select),
		.flash_serial_clock(link.flash_serial_clock),
		.flash_serial_out(link.flash_serial_out),
		.flash_select_n(link.flash_select_n),
		.flash_select_n_oe(link.flash_select_n_oe),
		.companion_select_n(link.companion_select_n),
		.init_done_irq_pin(link.init_done_irq_pin));
	always #2 aclk = ~aclk;
	// flash: word leaves on falling clock after the 32 command and address bits
	always @(negedge link.flash_serial_clock)
		if (!link.flash_select_n && n_rise >= 32 && n_rise < 64)
			flash_in <= flash_word[63 - n_rise];
	always @(posedge link.flash_serial_clock)
		if (!link.flash_select_n)
			n_rise <= n_rise + 1;
	always @(negedge link.flash_select_n) n_rise <= 0;
	// released line must not keep its last value
	always @(posedge link.flash_select_n) flash_in <= ~flash_in;
	// a hang counts as a mismatch
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			complete_run;
		end
	end
	task automatic complete_run;
		if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic ck(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// one AXI4-Lite transfer; readies are looked at before the edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		logic pa, pw, ka, kw, done;
		@(posedge aclk);
		pa = 1;
		pw = w;
		done = 0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		while (!done) begin
			@(negedge aclk);
			ka = pa && (w ? s_axi_awready : s_axi_arready);
			kw = pw && s_axi_wready;
			done = w ? s_axi_bvalid : s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ka) begin
				pa = 0;
				s_axi_awvalid <= 0;
				s_axi_arvalid <= 0;
			end
			if (kw) begin
				pw = 0;
				s_axi_wvalid <= 0;
			end
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
	endtask
	task automatic t_float;
		ck("enables", 0, {link.mirror_power_on_oe, link.emitter_driver_on_oe,
			link.emitter_select_oe, link.flash_serial_clock_oe,
			link.flash_serial_out_oe, link.flash_select_n_oe});
	endtask
	task automatic t_up(input logic [31:0] w, input logic bad);
		flash_word = w;
		bus(1, REG_IRQ_CLEAR, 32'hf);
		bus(1, REG_IRQ_ENABLE, 32'hf);
		bus(1, REG_CTRL, 32'h1);
		do @(negedge aclk); while (link.power_on_init_n !== 1'b1);
		ck("park at release", 1, link.mirror_park_n);
		t0 = cyc;
		do @(negedge aclk); while (i2c_grant !== 1'b1);
		ck("bus quiet", 1, cyc - t0 >= 40 && cyc - t0 <= 42);
		do @(negedge aclk); while (link.init_done_irq_pin !== 1'b1);
		do @(negedge aclk); while (cfg_done !== 1'b1);
		ck("last byte", w[7:0], cfg_value);
		ck("cfg error", bad, cfg_error);
		// done pulse, gap and error pulse are 16 cycles each
		repeat (80) @(negedge aclk);
		bus(0, REG_IRQ_STATUS, 0);
		ck("events", {bad, 1'b1}, rd[1:0]);
		ck("irq", 1, irq);
		if (!bad) ck("mirror power", 1, link.mirror_power_on);
	endtask
	task automatic t_light;
		bus(1, REG_CTRL, 32'h3);
		do @(negedge aclk); while (link.light_source_allow !== 1'b1);
		t0 = cyc;
		do @(negedge aclk); while (link.emitter_driver_on !== 1'b1);
		ck("light delay", 1, cyc - t0 >= 50 && cyc - t0 <= 56);
		ck("emitter select", 2'b10, link.emitter_select);
		bus(1, REG_CTRL, 32'h1);
		do @(negedge aclk); while (link.light_source_allow !== 1'b0);
		repeat (4) @(negedge aclk);
		ck("forced", 0, {link.emitter_driver_on, link.emitter_select});
	endtask
	task automatic t_down;
		bus(1, REG_CTRL, 32'h0);
		do @(negedge aclk); while (link.mirror_park_n !== 1'b0);
		t0 = cyc;
		do @(negedge aclk); while (link.power_on_init_n !== 1'b0);
		ck("park lead", 1, cyc - t0 >= 30 && cyc - t0 <= 32);
		ck("power off ok", 1, power_off_ok);
		bus(0, REG_STATUS, 0);
		ck("status", 32'h70, rd);
		repeat (4) @(negedge aclk);
		t_float;
	endtask
	// clear, mask, unmask, then an unmapped read
	task automatic t_irq;
		bus(1, REG_IRQ_CLEAR, 32'hf);
		bus(0, REG_IRQ_STATUS, 0);
		ck("cleared", 0, rd);
		ck("irq low", 0, irq);
		bus(1, REG_IRQ_ENABLE, 32'h0);
		supplies_good <= 0;
		do @(negedge aclk); while (power_off_ok !== 1'b1);
		bus(0, REG_IRQ_STATUS, 0);
		ck("off event", 1, rd[EV_POWER_OFF_OK]);
		ck("masked", 0, irq);
		bus(1, REG_IRQ_ENABLE, 32'h8);
		@(negedge aclk);
		ck("unmasked", 1, irq);
		bus(0, 5'h14, 0);
		ck("unmapped", RESP_SLVERR, rsp);
	endtask
	initial begin
		repeat (19) @(posedge aclk);
		@(negedge aclk);
		t_float;
		@(posedge aclk);
		aresetn <= 1;
		t_up(32'ha53c965a, 0);
		t_light;
		t_down;
		t_up(32'h11223344, 1);
		t_irq;
		complete_run;
	end
endmodule // tb_init_park_led_sequencing
`default_nettype wire

// [rtl/ipls_device.sv]
// Purpose: device end: self-configuration from flash, light gating
// Assumes: pins from the host are asynchronous and synchronised here
// Notes:   the init pin pulses once when done, again on a config error
`timescale 1ns/10ps
`default_nettype none
// Operation
// - configuration starts on init line rising
// - host releases init only with stable power
// - seven outputs float while init held low; six have enables here
// - host raises park before or soon after
// - host lowers park 500 us before power-off
// - light disallowed forces emitter outputs off
// - emitter outputs released 100 ms after allow
// - host waits 100 ms before control bus
// - flash selected by first active-low select
// - companion selected by second active-low select
// - command, address, data leave on serial out
// - init pin pulses done, later error pulse
module ipls_device
	import ipls_pkg::*;
#(
	parameter int LED_WAIT = LED_WAIT_CYC,
	parameter logic [7:0] SIGNATURE = CFG_SIG
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link
	ipls_link_if.dev link,
	// user side
	input wire logic emitter_on_req,
	input wire logic [1:0] emitter_sel_req,
	output logic cfg_done,
	output logic cfg_error,
	output logic [7:0] cfg_value
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_SEND = 3'h1,
		S_READ = 3'h3,
		S_COMP = 3'h2,
		S_DONE = 3'h6,
		S_RUN = 3'h7,
		S_ERRP = 3'h5
	} ipls_dev_st_t;

	typedef struct packed {
		logic rst_s1, rst_s2, rst_s3;
		logic allow_s1, allow_s2;
		logic park_s1, park_s2;
		logic miso_s1, miso_s2;
		ipls_dev_st_t st;
		logic [3:0] div;
		logic sck;
		logic mosi;
		logic cs0_act, cs1_act;
		logic [4:0] bits;
		logic [7:0] bytes;
		logic [31:0] sh;
		logic [7:0] cfg;
		logic err, err_sent;
		logic [7:0] pcnt;
		logic pin;
		logic [TMR_W-1:0] led_cnt;
		logic led_ok;
		logic mirror, em_on;
		logic [1:0] em_sel;
	} ipls_dev_t;

	localparam logic [3:0] DIV_HALF = 4'(SPI_HALF);
	localparam logic [3:0] DIV_LAST = 4'(2 * SPI_HALF - 1);
	localparam logic [4:0] CMD_LAST = 5'h1f;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [7:0] LAST_BYTE = 8'(CFG_BYTES - 1);
	localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYC - 1);
	localparam logic [TMR_W-1:0] LED_LAST = TMR_W'(LED_WAIT - 1);

	ipls_dev_t r_reg, r_next;

	function automatic logic in_serial(input ipls_dev_st_t s);
		in_serial = (s == S_SEND) || (s == S_READ) || (s == S_COMP);
	endfunction

	function automatic logic configured(input ipls_dev_st_t s);
		configured = (s == S_RUN) || (s == S_ERRP);
	endfunction

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// one pass computes every field; reset of the link dominates at the end
	always_comb begin
		logic bit_end;
		logic [7:0] rx;
		r_next = r_reg;
		bit_end = (r_reg.div == DIV_LAST);
		rx = {r_reg.sh[6:0], r_reg.miso_s2};
		// two-stage synchronisers for every pin from outside
		r_next.rst_s1 = link.power_on_init_n;
		r_next.rst_s2 = r_reg.rst_s1;
		r_next.rst_s3 = r_reg.rst_s2;
		r_next.allow_s1 = link.light_source_allow;
		r_next.allow_s2 = r_reg.allow_s1;
		r_next.park_s1 = link.mirror_park_n;
		r_next.park_s2 = r_reg.park_s1;
		r_next.miso_s1 = link.flash_serial_in;
		r_next.miso_s2 = r_reg.miso_s1;

		// light settle timer restarts on every low of the allow input
		if (!r_reg.allow_s2) begin
			r_next.led_cnt = '0;
			r_next.led_ok = 1'b0;
		end else if (!r_reg.led_ok) begin
			if (r_reg.led_cnt == LED_LAST) begin
				r_next.led_ok = 1'b1;
			end else begin
				r_next.led_cnt = r_reg.led_cnt + 1'b1;
			end
		end

		// serial clock divider, low half first so data leads the edge
		if (in_serial(r_reg.st)) begin
			r_next.div = bit_end ? '0 : r_reg.div + 1'b1;
		end else begin
			r_next.div = '0;
		end

		case (r_reg.st)
			S_IDLE: begin
				if (r_reg.rst_s2 && !r_reg.rst_s3) begin
					r_next.st = S_SEND;
					r_next.cs0_act = 1'b1;
					r_next.sh = {FLASH_CMD_READ, CFG_ADDR};
					r_next.bits = '0;
				end
			end
			S_SEND: begin
				if (bit_end) begin
					r_next.sh = {r_reg.sh[30:0], 1'b0};
					r_next.bits = r_reg.bits + 1'b1;
					if (r_reg.bits == CMD_LAST) begin
						r_next.st = S_READ;
						r_next.bits = '0;
						r_next.bytes = '0;
					end
				end
			end
			S_READ: begin
				if (bit_end) begin
					r_next.sh = {r_reg.sh[30:0], r_reg.miso_s2};
					r_next.bits = r_reg.bits + 1'b1;
					if (r_reg.bits == BYTE_LAST) begin
						r_next.bits = '0;
						r_next.bytes = r_reg.bytes + 1'b1;
						r_next.cfg = rx;
						if (r_reg.bytes == '0 && rx != SIGNATURE) begin
							r_next.err = 1'b1;
						end
						// last byte is forwarded to the companion
						if (r_reg.bytes == LAST_BYTE) begin
							r_next.cs0_act = 1'b0;
							r_next.cs1_act = 1'b1;
							r_next.sh = {rx, 24'h000000};
							r_next.st = S_COMP;
						end
					end
				end
			end
			S_COMP: begin
				if (bit_end) begin
					r_next.sh = {r_reg.sh[30:0], 1'b0};
					r_next.bits = r_reg.bits + 1'b1;
					if (r_reg.bits == BYTE_LAST) begin
						r_next.cs1_act = 1'b0;
						r_next.st = S_DONE;
						r_next.pin = 1'b1;
						r_next.pcnt = '0;
					end
				end
			end
			S_DONE: begin
				r_next.pcnt = r_reg.pcnt + 1'b1;
				if (r_reg.pcnt == PULSE_LAST) begin
					r_next.pin = 1'b0;
					r_next.pcnt = '0;
					r_next.st = S_RUN;
				end
			end
			S_RUN: begin
				// a low gap keeps the error pulse apart from the done pulse
				if (r_reg.err && !r_reg.err_sent) begin
					r_next.pcnt = r_reg.pcnt + 1'b1;
					if (r_reg.pcnt == PULSE_LAST) begin
						r_next.pin = 1'b1;
						r_next.pcnt = '0;
						r_next.st = S_ERRP;
					end
				end
			end
			S_ERRP: begin
				r_next.pcnt = r_reg.pcnt + 1'b1;
				if (r_reg.pcnt == PULSE_LAST) begin
					r_next.pin = 1'b0;
					r_next.err_sent = 1'b1;
					r_next.st = S_RUN;
				end
			end
			default: begin
				r_next.st = S_IDLE;
			end
		endcase

		// registered pin values, mode 0: data changes with the falling edge
		r_next.sck = in_serial(r_next.st) && (r_next.div >= DIV_HALF);
		r_next.mosi = ((r_next.st == S_SEND) || (r_next.st == S_COMP)) &&
			r_next.sh[31];
		r_next.mirror = configured(r_next.st) && r_reg.park_s2;
		r_next.em_on = configured(r_next.st) && r_reg.allow_s2 &&
			r_next.led_ok && emitter_on_req;
		r_next.em_sel = (configured(r_next.st) && r_reg.allow_s2 &&
			r_next.led_ok) ? emitter_sel_req : 2'h0;

		// init line held low: abandon everything and wait for its rise
		if (!r_reg.rst_s2) begin
			r_next.st = S_IDLE;
			r_next.div = '0;
			r_next.sck = 1'b0;
			r_next.mosi = 1'b0;
			r_next.cs0_act = 1'b0;
			r_next.cs1_act = 1'b0;
			r_next.err = 1'b0;
			r_next.err_sent = 1'b0;
			r_next.pcnt = '0;
			r_next.pin = 1'b0;
			r_next.mirror = 1'b0;
			r_next.em_on = 1'b0;
			r_next.em_sel = 2'h0;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// enables follow the synchronised init line, two cycles behind the pin
	assign link.mirror_power_on_oe = r_reg.rst_s2;
	assign link.emitter_driver_on_oe = r_reg.rst_s2;
	assign link.emitter_select_oe = r_reg.rst_s2;
	assign link.flash_serial_clock_oe = r_reg.rst_s2;
	assign link.flash_serial_out_oe = r_reg.rst_s2;
	assign link.flash_select_n_oe = r_reg.rst_s2;
	assign link.mirror_power_on = r_reg.mirror;
	assign link.emitter_driver_on = r_reg.em_on;
	assign link.emitter_select = r_reg.em_sel;
	assign link.flash_serial_clock = r_reg.sck;
	assign link.flash_serial_out = r_reg.mosi;
	assign link.flash_select_n = ~r_reg.cs0_act;
	assign link.companion_select_n = ~r_reg.cs1_act;
	assign link.init_done_irq_pin = r_reg.pin;
	assign cfg_done = configured(r_reg.st);
	assign cfg_error = r_reg.err;
	assign cfg_value = r_reg.cfg;
endmodule // ipls_device
`default_nettype wire

// [rtl/ipls_host.sv]
// Purpose: host end: drives init, park and light allow under software
// Assumes: software reaches the control registers over AXI4-Lite
// Notes:   supplies may be removed only while power_off_ok is high
`timescale 1ns/10ps
`default_nettype none
module ipls_host
	import ipls_pkg::*;
#(
	parameter int I2C_QUIET = I2C_QUIET_CYC,
	parameter int PARK_LEAD = PARK_LEAD_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// system side
	input wire logic supplies_good,
	output logic i2c_grant,
	output logic power_off_ok,
	output logic irq,
	// link
	ipls_link_if.host link
);
	typedef enum logic [1:0] {
		H_OFF = 2'h0,
		H_PARKUP = 2'h1,
		H_RUN = 2'h3,
		H_DOWN = 2'h2
	} ipls_host_st_t;

	typedef struct packed {
		logic aw_have, w_have;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic wstrb0;
		logic bvalid, rvalid;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		logic [1:0] ctrl;
		logic [EV_W-1:0] irq_en, irq_st;
		ipls_host_st_t st;
		logic [TMR_W-1:0] tmr;
		logic rst, park, allow, i2c_ok, off_ok, init_seen;
		logic pin_s1, pin_s2, pin_s3, sup_s1, sup_s2;
	} ipls_host_t;

	localparam logic [TMR_W-1:0] HOLD_LAST = TMR_W'(RST_HOLD_CYC - 1);
	localparam logic [TMR_W-1:0] QUIET_LAST = TMR_W'(I2C_QUIET - 1);
	localparam logic [TMR_W-1:0] LEAD_LAST = TMR_W'(PARK_LEAD - 1);

	ipls_host_t r_reg, r_next;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [EV_W-1:0] ev, clr;
		ev = '0;
		clr = '0;
		r_next = r_reg;
		r_next.pin_s1 = link.init_done_irq_pin;
		r_next.pin_s2 = r_reg.pin_s1;
		r_next.pin_s3 = r_reg.pin_s2;
		r_next.sup_s1 = supplies_good;
		r_next.sup_s2 = r_reg.sup_s1;

		// write: address and data in either order, then one response
		if (s_axi_awvalid && s_axi_awready) begin
			r_next.aw_have = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			r_next.w_have = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb0 = s_axi_wstrb[0];
		end
		if (r_reg.aw_have && r_reg.w_have) begin
			r_next.aw_have = 1'b0;
			r_next.w_have = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = RESP_OKAY;
			case (r_reg.awaddr)
				REG_CTRL: if (r_reg.wstrb0) r_next.ctrl = r_reg.wdata[1:0];
				REG_IRQ_CLEAR: if (r_reg.wstrb0) clr = r_reg.wdata[EV_W-1:0];
				REG_IRQ_ENABLE: begin
					if (r_reg.wstrb0) r_next.irq_en = r_reg.wdata[EV_W-1:0];
				end
				REG_STATUS, REG_IRQ_STATUS: r_next.bresp = RESP_OKAY;
				default: r_next.bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready) r_next.bvalid = 1'b0;

		// read: one cycle from address to data
		if (s_axi_arvalid && s_axi_arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = RESP_OKAY;
			r_next.rdata = '0;
			case (s_axi_araddr)
				REG_CTRL: r_next.rdata[1:0] = r_reg.ctrl;
				REG_STATUS: r_next.rdata[6:0] = {r_reg.sup_s2,
					r_reg.init_seen, r_reg.off_ok, r_reg.i2c_ok, r_reg.rst,
					r_reg.st};
				REG_IRQ_STATUS: r_next.rdata[EV_W-1:0] = r_reg.irq_st;
				REG_IRQ_ENABLE: r_next.rdata[EV_W-1:0] = r_reg.irq_en;
				REG_IRQ_CLEAR: r_next.rdata = '0;
				default: r_next.rresp = RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end

		// power sequence
		r_next.tmr = r_reg.tmr + 1'b1;
		case (r_reg.st)
			H_OFF: begin
				if (r_reg.tmr == HOLD_LAST) r_next.tmr = r_reg.tmr;
				// init release waits for supplies and clock to settle
				if (r_reg.ctrl[CTRL_RUN] && r_reg.sup_s2 &&
					r_reg.tmr == HOLD_LAST) begin
					r_next.st = H_PARKUP;
					r_next.park = 1'b1;
					r_next.off_ok = 1'b0;
					r_next.init_seen = 1'b0;
				end
			end
			H_PARKUP: begin
				r_next.rst = 1'b1;
				r_next.tmr = '0;
				r_next.st = H_RUN;
			end
			H_RUN: begin
				if (r_reg.tmr == QUIET_LAST) begin
					r_next.tmr = r_reg.tmr;
					if (!r_reg.i2c_ok) ev[EV_I2C_OPEN] = 1'b1;
					r_next.i2c_ok = 1'b1;
				end
				r_next.allow = r_reg.ctrl[CTRL_LIGHT];
				if (r_reg.pin_s3 && !r_reg.pin_s2 && !r_reg.init_seen) begin
					r_next.init_seen = 1'b1;
					ev[EV_INIT_DONE] = 1'b1;
				end
				if (r_reg.pin_s2 && !r_reg.pin_s3 && r_reg.init_seen) begin
					ev[EV_ERROR] = 1'b1;
				end
				if (!r_reg.ctrl[CTRL_RUN] || !r_reg.sup_s2) begin
					r_next.st = H_DOWN;
					r_next.park = 1'b0;
					r_next.allow = 1'b0;
					r_next.i2c_ok = 1'b0;
					r_next.tmr = '0;
				end
			end
			H_DOWN: begin
				if (r_reg.tmr == LEAD_LAST) begin
					r_next.rst = 1'b0;
					r_next.off_ok = 1'b1;
					ev[EV_POWER_OFF_OK] = 1'b1;
					r_next.tmr = '0;
					r_next.st = H_OFF;
				end
			end
			default: r_next.st = H_OFF;
		endcase

		// a new event wins over a clear in the same cycle
		r_next.irq_st = (r_reg.irq_st & ~clr) | ev;
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign s_axi_awready = !r_reg.aw_have && !r_reg.bvalid;
	assign s_axi_wready = !r_reg.w_have && !r_reg.bvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign i2c_grant = r_reg.i2c_ok;
	assign power_off_ok = r_reg.off_ok;
	assign irq = |(r_reg.irq_st & r_reg.irq_en);
	assign link.power_on_init_n = r_reg.rst;
	assign link.mirror_park_n = r_reg.park;
	assign link.light_source_allow = r_reg.allow;
endmodule // ipls_host
`default_nettype wire

// [rtl/ipls_link_if.sv]
// Purpose: pins between the host/power manager and the display device
// Assumes: each three-state output carries its value and an enable
// Notes:   the bench reads the value and the enable of the three-state pins directly
`timescale 1ns/10ps
`default_nettype none
interface ipls_link_if;
	// driven by the host
	logic power_on_init_n;
	logic mirror_park_n;
	logic light_source_allow;
	// driven by the device; those with an enable are three-state while in reset
	logic mirror_power_on;
	logic mirror_power_on_oe;
	logic emitter_driver_on;
	logic emitter_driver_on_oe;
	logic [1:0] emitter_select;
	logic emitter_select_oe;
	logic flash_serial_clock;
	logic flash_serial_clock_oe;
	logic flash_serial_out;
	logic flash_serial_out_oe;
	logic flash_select_n;
	logic flash_select_n_oe;
	logic companion_select_n;
	logic init_done_irq_pin;
	// driven by the flash
	logic flash_serial_in;

	modport dev (
		input power_on_init_n, mirror_park_n, light_source_allow,
		input flash_serial_in,
		output mirror_power_on, mirror_power_on_oe,
		output emitter_driver_on, emitter_driver_on_oe,
		output emitter_select, emitter_select_oe,
		output flash_serial_clock, flash_serial_clock_oe,
		output flash_serial_out, flash_serial_out_oe,
		output flash_select_n, flash_select_n_oe,
		output companion_select_n, init_done_irq_pin
	);
	modport host (
		output power_on_init_n, mirror_park_n, light_source_allow,
		input init_done_irq_pin
	);
endinterface
`default_nettype wire

// [rtl/ipls_pkg.sv]
// Purpose: shared constants for the power sequencer host and device ends
// Assumes: one 250 MHz clock shared by both ends
// Notes:   times are kept in their own units; cycle counts derive from them
package ipls_pkg;
	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int LED_WAIT_MS = 100;
	localparam int I2C_QUIET_MS = 100;
	localparam int PARK_LEAD_US = 500;
	localparam int LED_WAIT_CYC = LED_WAIT_MS * 1000 * CLK_MHZ;
	localparam int I2C_QUIET_CYC = I2C_QUIET_MS * 1000 * CLK_MHZ;
	localparam int PARK_LEAD_CYC = PARK_LEAD_US * CLK_MHZ;
	localparam int RST_HOLD_CYC = 16;
	localparam int TMR_W = 25;
	// ------------------------------------------------------------------
	// serial flash port
	// ------------------------------------------------------------------
	localparam int SPI_HALF = 4; // 31.25 MHz serial clock
	localparam logic [7:0] FLASH_CMD_READ = 8'h03;
	localparam logic [23:0] CFG_ADDR = 24'h000000;
	localparam int CFG_BYTES = 4;
	localparam logic [7:0] CFG_SIG = 8'ha5; // arbitrary signature value
	localparam int PULSE_CYC = 16;
	// ------------------------------------------------------------------
	// host register map (byte addresses) and fields
	// ------------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_IRQ_STATUS = 5'h08;
	localparam logic [4:0] REG_IRQ_CLEAR = 5'h0c;
	localparam logic [4:0] REG_IRQ_ENABLE = 5'h10;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_LIGHT = 1;
	localparam int EV_INIT_DONE = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_I2C_OPEN = 2;
	localparam int EV_POWER_OFF_OK = 3;
	localparam int EV_W = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
